/* include/srv_pkg.sv */
`default_nettype none
package srv_pkg;
    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_VFCNT = 8'h04;
    localparam logic [7:0] REG_OFFSET = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_PF0_BASE = 8'h40;
    localparam logic [7:0] REG_PF1_BASE = 8'h80;
    localparam logic [5:0] PF_CAPCFG = 6'h00;
    localparam logic [5:0] PF_VFDEVID = 6'h04;
    localparam logic [5:0] PF_PAGES = 6'h08;
    localparam logic [5:0] PF_BAR0 = 6'h10;
    localparam logic [5:0] PF_BAR5 = 6'h24;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int VFCNT_PF1_LSB = 8;
    localparam int OFFSET_PF1_LSB = 16;
    localparam int CAPCFG_LINK_LSB = 16;
    localparam int STATUS_TOTAL_LSB = 3;

    // ----------------------------------------
    // Function numbering
    // ----------------------------------------
    localparam logic [2:0] MAX_VFS = 3'h6;
    localparam logic [7:0] PF0_FN = 8'h00;
    localparam logic [7:0] PF1_FN = 8'h01;
    localparam logic [7:0] VF_FN_BASE = 8'h40;
    localparam logic [15:0] PF0_FIRST_OFF = 16'h0040;
    localparam logic [15:0] PF1_OFF_BASE = 16'h003F;

    // ----------------------------------------
    // BAR limits, log2 of bytes
    // ----------------------------------------
    localparam int BAR_SLOTS = 6;
    localparam int ROOT_SLOTS = 2;
    localparam logic [6:0] BAR32_MIN_LOG = 7'h04;
    localparam logic [6:0] BAR32_MAX_LOG = 7'h1F;
    localparam logic [6:0] BAR64_MIN_LOG = 7'h07;
    localparam logic [6:0] BAR64_MAX_LOG = 7'h3F;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h04;
    localparam logic [31:0] PAGES_RESET = 32'h0000_0001;
    localparam logic [15:0] LINK_PF1_RESET = 16'h0001;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic tph;
        logic cas128;
        logic atomic64;
        logic atomic32;
        logic flrEn;
        logic endpoint;
        logic pf1En;
        logic sriovEn;
    } srv_ctrl_s;

    typedef struct packed {
        logic [15:0] depLink;
        logic [3:0] capVer;
        logic [15:0] vfDevId;
        logic [31:0] pageSizes;
    } srv_pf_s;

    typedef struct packed {
        logic [6:0] sizeLog;
        logic io;
        logic prefetch;
        logic is64;
        logic enable;
    } srv_bar_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } srv_bus_s;

    typedef struct packed {
        logic [7:0] fnNum;
        logic valid;
    } srv_fnq_s;

    typedef struct packed {
        logic done;
        logic claimed;
        logic isVf;
        logic pf;
        logic [2:0] vfIdx;
        logic [15:0] devId;
    } srv_fn_s;
endpackage
`default_nettype wire

/* logic/srv_function_map.sv */
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Virtualization capability exists for function 0 when enabled, and for function 1 when it and function one are both enabled.
// - Per-function reset offered only in endpoint configuration.
// - Atomic and hint completer bits reported identically by both functions while function one is enabled; zero for function one otherwise.
// - Each physical function has a four-bit capability version.
// - At most six virtual functions shared; each function has its own count.
// - Physical function zero is number 0, function one is number 1.
// - Virtual functions occupy numbers 64 to 69 only.
// - Virtual numbers consecutive, function zero's children first.
// - First-child offset equals first child number minus own number.
// - Function zero's first-child offset is 64 when it has children.
// - Function one's first-child offset is 63 plus function zero's count.
// - All children of one function report that function's 16-bit device ID.
// - Page size bitmap: bit n means pages of 2 to the n plus 12.
// - Endpoint: six 32-bit or three 64-bit BARs per function.
// - Root port: two 32-bit BARs or one 64-bit BAR.
// - A 32-bit BAR spans 16 bytes up to 2 gigabytes.
// - A 64-bit BAR is memory only, 128 bytes up to 8 exabytes.
// - Each BAR has its own enable; disabled BARs claim nothing.
// - A 64-bit BAR consumes the next slot as its upper half.
// - Endpoint prefetchable BARs below the last slot must be 64-bit.
module srv_function_map
    import srv_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire srv_bus_s bus,
    output logic [DATA_W-1:0] rdData,
    // Function number lookup
    input wire srv_fnq_s fnQuery,
    output srv_fn_s fnResult,
    // Derived configuration
    output logic [15:0] firstOffset0,
    output logic [15:0] firstOffset1,
    output logic [1:0] capPresent,
    output logic flrSupported,
    output logic [3:0] devCap2Pf0,
    output logic [3:0] devCap2Pf1,
    output logic [2*BAR_SLOTS-1:0] barActive
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        srv_ctrl_s ctrl;
        logic [2:0] cnt0;
        logic [2:0] cnt1;
        srv_pf_s [1:0] pf;
        srv_bar_s [1:0][BAR_SLOTS-1:0] bar;
        logic [DATA_W-1:0] rdData;
        srv_fn_s fnRes;
        logic [15:0] off0;
        logic [15:0] off1;
        logic [1:0] capPresent;
        logic flr;
        logic [3:0] dc2Pf0;
        logic [3:0] dc2Pf1;
        logic [2*BAR_SLOTS-1:0] barActive;
    } srv_state_s;

    srv_state_s state;
    srv_state_s next_state;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [BAR_SLOTS-1:0] barUsable(
        input srv_bar_s [BAR_SLOTS-1:0] b,
        input logic ep
    );
        logic [BAR_SLOTS-1:0] res;
        logic consumed;
        logic ok;
        res = '0;
        consumed = 1'b0;
        for (int i = 0; i < BAR_SLOTS; i++) begin
            ok = b[i].enable && !consumed;
            if (!ep && i >= ROOT_SLOTS) begin
                ok = 1'b0;
            end
            if (b[i].is64) begin
                if (b[i].io || b[i].sizeLog < BAR64_MIN_LOG
                        || b[i].sizeLog > BAR64_MAX_LOG) begin
                    ok = 1'b0;
                end
                if (i == BAR_SLOTS - 1 || (!ep && i + 1 >= ROOT_SLOTS)) begin
                    ok = 1'b0;
                end
            end else begin
                if (b[i].sizeLog < BAR32_MIN_LOG || b[i].sizeLog > BAR32_MAX_LOG) begin
                    ok = 1'b0;
                end
                if (ep && b[i].prefetch && i < BAR_SLOTS - 1) begin
                    ok = 1'b0;
                end
            end
            res[i] = ok;
            consumed = ok && b[i].is64;
        end
        return res;
    endfunction

    function automatic logic [2:0] minCnt(input logic [2:0] a, input logic [2:0] b);
        return (a < b) ? a : b;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [2:0] eff0;
        logic [2:0] eff1;
        logic [2:0] total;
        logic [7:0] vfIdx;
        logic [7:0] rel;
        logic pfSel;
        logic [5:0] sub;
        logic [2:0] slot;
        logic [3:0] dc2;
        eff0 = '0;
        eff1 = '0;
        total = '0;
        vfIdx = '0;
        rel = '0;
        pfSel = 1'b0;
        sub = '0;
        slot = '0;
        dc2 = '0;
        next_state = state;

        if (state.ctrl.sriovEn) begin
            eff0 = minCnt(state.cnt0, MAX_VFS);
            if (state.ctrl.pf1En) begin
                eff1 = minCnt(state.cnt1, 3'(MAX_VFS - eff0));
            end
        end
        total = 3'(eff0 + eff1);

        // Register writes
        pfSel = bus.addr[7];
        sub = bus.addr[5:0];
        slot = 3'((sub - PF_BAR0) >> 2);
        if (bus.wr) begin
            if (bus.addr == REG_CTRL) begin
                next_state.ctrl = srv_ctrl_s'(bus.wdata[7:0]);
            end else if (bus.addr == REG_VFCNT) begin
                next_state.cnt0 = bus.wdata[2:0];
                next_state.cnt1 = bus.wdata[VFCNT_PF1_LSB +: 3];
            end else if (bus.addr[7:6] == REG_PF0_BASE[7:6]
                    || bus.addr[7:6] == REG_PF1_BASE[7:6]) begin
                if (sub == PF_CAPCFG) begin
                    next_state.pf[pfSel].capVer = bus.wdata[3:0];
                    next_state.pf[pfSel].depLink = bus.wdata[CAPCFG_LINK_LSB +: 16];
                end else if (sub == PF_VFDEVID) begin
                    next_state.pf[pfSel].vfDevId = bus.wdata[15:0];
                end else if (sub == PF_PAGES) begin
                    next_state.pf[pfSel].pageSizes = bus.wdata;
                end else if (sub >= PF_BAR0 && sub <= PF_BAR5 && sub[1:0] == 2'b00) begin
                    next_state.bar[pfSel][slot] = srv_bar_s'(bus.wdata[10:0]);
                end
            end
        end

        // Register reads
        next_state.rdData = '0;
        if (bus.rd) begin
            if (bus.addr == REG_CTRL) begin
                next_state.rdData = {24'h00_0000, state.ctrl};
            end else if (bus.addr == REG_VFCNT) begin
                next_state.rdData[2:0] = state.cnt0;
                next_state.rdData[VFCNT_PF1_LSB +: 3] = state.cnt1;
            end else if (bus.addr == REG_OFFSET) begin
                next_state.rdData = {state.off1, state.off0};
            end else if (bus.addr == REG_STATUS) begin
                next_state.rdData[1:0] = state.capPresent;
                next_state.rdData[2] = state.flr;
                next_state.rdData[STATUS_TOTAL_LSB +: 3] = total;
            end else if (bus.addr[7:6] == REG_PF0_BASE[7:6]
                    || bus.addr[7:6] == REG_PF1_BASE[7:6]) begin
                if (sub == PF_CAPCFG) begin
                    next_state.rdData[3:0] = state.pf[pfSel].capVer;
                    next_state.rdData[CAPCFG_LINK_LSB +: 16] = state.pf[pfSel].depLink;
                end else if (sub == PF_VFDEVID) begin
                    next_state.rdData[15:0] = state.pf[pfSel].vfDevId;
                end else if (sub == PF_PAGES) begin
                    next_state.rdData = state.pf[pfSel].pageSizes;
                end else if (sub >= PF_BAR0 && sub <= PF_BAR5 && sub[1:0] == 2'b00) begin
                    next_state.rdData[10:0] = state.bar[pfSel][slot];
                end
            end
        end

        next_state.capPresent[0] = state.ctrl.sriovEn;
        next_state.capPresent[1] = state.ctrl.sriovEn && state.ctrl.pf1En;

        next_state.flr = state.ctrl.flrEn && state.ctrl.endpoint;

        dc2 = {state.ctrl.tph, state.ctrl.cas128, state.ctrl.atomic64, state.ctrl.atomic32};
        next_state.dc2Pf0 = dc2;
        next_state.dc2Pf1 = state.ctrl.pf1En ? dc2 : 4'h0;

        next_state.off0 = (eff0 != 3'h0) ? PF0_FIRST_OFF : 16'h0000;
        next_state.off1 = next_state.capPresent[1] ? 16'(PF1_OFF_BASE + eff0) : 16'h0000;

        next_state.barActive[0 +: BAR_SLOTS] = barUsable(state.bar[0], state.ctrl.endpoint);
        next_state.barActive[BAR_SLOTS +: BAR_SLOTS] =
            state.ctrl.pf1En ? barUsable(state.bar[1], state.ctrl.endpoint) : '0;

        // Function number lookup
        next_state.fnRes = '0;
        if (fnQuery.valid) begin
            next_state.fnRes.done = 1'b1;
            rel = 8'(fnQuery.fnNum - VF_FN_BASE);
            if (fnQuery.fnNum == PF0_FN) begin
                next_state.fnRes.claimed = 1'b1;
            end else if (fnQuery.fnNum == PF1_FN) begin
                next_state.fnRes.claimed = state.ctrl.pf1En;
                next_state.fnRes.pf = 1'b1;
            end else if (fnQuery.fnNum >= VF_FN_BASE && rel < 8'(total)) begin
                next_state.fnRes.claimed = 1'b1;
                next_state.fnRes.isVf = 1'b1;
                if (rel < 8'(eff0)) begin
                    vfIdx = rel;
                    next_state.fnRes.pf = 1'b0;
                end else begin
                    vfIdx = 8'(rel - 8'(eff0));
                    next_state.fnRes.pf = 1'b1;
                end
                next_state.fnRes.vfIdx = vfIdx[2:0];
                next_state.fnRes.devId = state.pf[next_state.fnRes.pf].vfDevId;
            end
        end

        if (srst) begin
            next_state = '0;
            next_state.ctrl = srv_ctrl_s'(CTRL_RESET);
            next_state.pf[0].pageSizes = PAGES_RESET;
            next_state.pf[1].pageSizes = PAGES_RESET;
            next_state.pf[1].depLink = LINK_PF1_RESET;
        end
    end

    always_ff @(posedge clk) begin
        state <= next_state;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdData = state.rdData;
    assign fnResult = state.fnRes;
    assign firstOffset0 = state.off0;
    assign firstOffset1 = state.off1;
    assign capPresent = state.capPresent;
    assign flrSupported = state.flr;
    assign devCap2Pf0 = state.dc2Pf0;
    assign devCap2Pf1 = state.dc2Pf1;
    assign barActive = state.barActive;

endmodule
`default_nettype wire

/* bench/srv_function_map_props.sv */
`timescale 1ns/1ns
`default_nettype none
module srv_function_map_props
    import srv_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port and lookup
    input wire srv_bus_s bus,
    input wire logic [DATA_W-1:0] rdData,
    input wire srv_fnq_s fnQuery,
    input wire srv_fn_s fnResult,
    // Derived configuration
    input wire logic [15:0] firstOffset0,
    input wire logic [15:0] firstOffset1,
    input wire logic [1:0] capPresent,
    input wire logic flrSupported,
    input wire logic [3:0] devCap2Pf0,
    input wire logic [3:0] devCap2Pf1,
    input wire logic [2*BAR_SLOTS-1:0] barActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_CAP_ORDER: assert property (capPresent[1] |-> capPresent[0])
        else $error("function one capability without function zero");
    AST_DEVCAP_SAME: assert property (devCap2Pf1 != 4'h0 |-> devCap2Pf1 == devCap2Pf0)
        else $error("completer bits differ between functions");
    AST_PF0_NUMBER: assert property (fnQuery.valid && fnQuery.fnNum == 8'h00
        |=> fnResult.claimed && !fnResult.isVf && !fnResult.pf)
        else $error("function zero not at number zero");
    AST_VF_RANGE: assert property (fnQuery.valid && (fnQuery.fnNum > 8'h45
        || (fnQuery.fnNum > 8'h01 && fnQuery.fnNum < 8'h40)) |=> fnResult.done && !fnResult.claimed)
        else $error("number outside child range claimed");
    AST_VF_NUMBER: assert property (fnQuery.valid |=> !fnResult.isVf
        || {8'h00, $past(fnQuery.fnNum)} == (fnResult.pf ? firstOffset1 + 16'h0001 : 16'h0040)
        + {13'h0000, fnResult.vfIdx})
        else $error("child numbering not consecutive");
    AST_OFF0_VALUE: assert property (firstOffset0 != 16'h0000
        |-> firstOffset0 == 16'h0040)
        else $error("function zero offset not 64");
    AST_OFF1_VALUE: assert property (firstOffset1 != 16'h0000 |-> firstOffset1 >= 16'h003F
        && firstOffset1 <= 16'h0045 && (firstOffset0 != 16'h0000 || firstOffset1 == 16'h003F))
        else $error("function one offset out of range");
    AST_RESET_CLEAR: assert property (disable iff (1'b0) srst |=> barActive == '0
        && firstOffset0 == 16'h0000 && capPresent == 2'h0)
        else $error("derived outputs not cleared by reset");
    AST_DONE_PULSE: assert property (fnResult.done == $past(fnQuery.valid))
        else $error("lookup answer not one cycle after query");
    AST_READ_IDLE: assert property (!bus.rd |=> rdData == '0)
        else $error("read data outside read answer");
endmodule
bind srv_function_map srv_function_map_props props_u (.clk, .srst, .bus, .rdData, .fnQuery,
    .fnResult, .firstOffset0, .firstOffset1, .capPresent, .flrSupported, .devCap2Pf0,
    .devCap2Pf1, .barActive);
`default_nettype wire

/* bench/srv_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module srv_host_model
    import srv_pkg::*;
(
    // Clock
    input wire logic clk,
    // Lookup port
    output var srv_fnq_s fnQuery,
    input wire srv_fn_s fnResult
);
    initial fnQuery = '0;
    // Enumeration probe, optional idle gap before it
    task automatic ask(input logic [7:0] fn, input int gap, output srv_fn_s res);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        fnQuery <= '{fnNum: fn, valid: 1'b1};
        @(posedge clk);
        fnQuery <= '0;
        #1 res = fnResult;
    endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin numErrors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
    import srv_pkg::*;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [31:0] cnt;
        logic [31:0] off;
        logic [31:0] stat;
    } srv_row_s;
    logic clk, srst;
    srv_bus_s bus;
    logic [DATA_W-1:0] rdData;
    srv_fnq_s fnQuery;
    srv_fn_s fnResult, res, expFn;
    logic [15:0] firstOffset0, firstOffset1;
    logic [1:0] capPresent;
    logic flrSupported;
    logic [3:0] devCap2Pf0, devCap2Pf1;
    logic [2*BAR_SLOTS-1:0] barActive;
    int numErrors = 0;
    int nTests = 0;
    int v;
    srv_row_s cfgRows [6] = '{
        '{8'hF7, 32'h0000_0302, 32'h0041_0040, 32'h0000_002B},
        '{8'h07, 32'h0000_0600, 32'h003F_0000, 32'h0000_0033},
        '{8'h07, 32'h0000_0606, 32'h0045_0040, 32'h0000_0033},
        '{8'h5D, 32'h0000_0107, 32'h0000_0040, 32'h0000_0035},
        '{8'h0B, 32'h0000_0101, 32'h0040_0040, 32'h0000_0013},
        '{8'h06, 32'h0000_0202, 32'h0000_0000, 32'h0000_0000}};
    logic [11:0] barRows [10] = '{12'h841, 12'h031, 12'h9F1, 12'h201, 12'h873,
        12'h063, 12'h07B, 12'h040, 12'h045, 12'hBF3};

    srv_function_map dut_u (.clk(clk), .srst(srst), .bus(bus), .rdData(rdData),
        .fnQuery(fnQuery), .fnResult(fnResult), .firstOffset0(firstOffset0),
        .firstOffset1(firstOffset1), .capPresent(capPresent), .flrSupported(flrSupported),
        .devCap2Pf0(devCap2Pf0), .devCap2Pf1(devCap2Pf1), .barActive(barActive));
    srv_host_model host_u (.clk(clk), .fnQuery(fnQuery), .fnResult(fnResult));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 `CHK(rdData, e)
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        numErrors++;
        complete_run();
    end

    initial begin
        srst = 1'b1;
        bus = '0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rdChk(REG_CTRL, 32'h0000_0004);
        rdChk(REG_PF0_BASE + 8'h08, 32'h0000_0001);
        rdChk(REG_PF1_BASE, 32'h0001_0000);
        wr(8'h30, 32'hFFFF_FFFF);
        rdChk(8'h30, 32'h0000_0000);
        // Capability version, dependency link and page bitmap
        wr(REG_PF0_BASE, 32'h1234_000F);
        rdChk(REG_PF0_BASE, 32'h1234_000F);
        wr(REG_PF1_BASE + 8'h08, 32'h0000_0013);
        rdChk(REG_PF1_BASE + 8'h08, 32'h0000_0013);
        $display("reset and register test done");
        foreach (cfgRows[i]) begin
            wr(REG_CTRL, {24'h00_0000, cfgRows[i].ctrl});
            wr(REG_VFCNT, cfgRows[i].cnt);
            settle();
            `CHK({firstOffset1, firstOffset0}, cfgRows[i].off)
            `CHK({flrSupported, capPresent}, cfgRows[i].stat[2:0])
            `CHK(devCap2Pf0, cfgRows[i].ctrl[7:4])
            `CHK(devCap2Pf1, (cfgRows[i].ctrl[1] ? cfgRows[i].ctrl[7:4] : 4'h0))
            rdChk(REG_OFFSET, cfgRows[i].off);
            rdChk(REG_STATUS, cfgRows[i].stat);
        end
        $display("configuration table done");
        wr(REG_CTRL, 32'h0000_0007);
        wr(REG_VFCNT, 32'h0000_0302);
        wr(REG_PF0_BASE + 8'h04, 32'h0000_A0A0);
        wr(REG_PF1_BASE + 8'h04, 32'h0000_B1B1);
        settle();
        host_u.ask(8'h01, 2, res);
        `CHK({res.claimed, res.isVf, res.pf}, 3'b101)
        host_u.ask(8'h00, 0, res);
        `CHK({res.done, res.claimed, res.isVf, res.pf}, 4'b1100)
        for (int fn = 62; fn <= 70; fn++) begin
            host_u.ask(fn[7:0], 0, res);
            v = fn - 64;
            expFn = '0;
            expFn.done = 1'b1;
            if (v >= 0 && v < 5) begin
                expFn.claimed = 1'b1;
                expFn.isVf = 1'b1;
                expFn.pf = (v >= 2);
                expFn.vfIdx = 3'((v >= 2) ? v - 2 : v);
                expFn.devId = (v >= 2) ? 16'hB1B1 : 16'hA0A0;
                `CHK(res, expFn)
            end else begin
                `CHK({res.done, res.claimed}, 2'b10)
            end
        end
        $display("lookup test done");
        foreach (barRows[i]) begin
            wr(REG_PF0_BASE + PF_BAR0, {21'h00_0000, barRows[i][10:0]});
            settle();
            `CHK(barActive[0], barRows[i][11])
        end
        // 64-bit slot swallows its neighbour
        wr(REG_PF0_BASE + PF_BAR0, 32'h0000_0073);
        wr(REG_PF0_BASE + PF_BAR0 + 8'h04, 32'h0000_0041);
        wr(REG_PF0_BASE + PF_BAR5, 32'h0000_0045);
        wr(REG_PF1_BASE + PF_BAR0, 32'h0000_0041);
        settle();
        `CHK(barActive, 12'h061)
        wr(REG_CTRL, 32'h0000_0001);
        settle();
        `CHK(barActive, 12'h001)
        host_u.ask(8'h42, 0, res);
        `CHK({res.done, res.claimed}, 2'b10)
        $display("window test done");
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        settle();
        `CHK(barActive, 12'h000)
        rdChk(REG_CTRL, 32'h0000_0004);
        $display("second reset test done");
        complete_run();
    end
endmodule
`default_nettype wire
